// ### irq_ctrl_defs.vh
// Constants for the interrupt latch and priority controller.
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
// Special-function addresses of the latch and enable registers.
`define ADDR_LATCH_EXT   8'h2E
`define ADDR_LATCH_LOW   8'h3C
`define ADDR_LATCH_HIGH  8'h3D
`define ADDR_ENABLE_EXT  8'h2C
`define ADDR_ENABLE_LOW  8'h3A
`define ADDR_ENABLE_HIGH 8'h3B
// Latch indices of the two latched non-maskable sources.
`define TRAP_BIT         2
`define WDOG_BIT         3
// Vector addresses.
`define VEC_RESET        16'hFFFE
`define VEC_SOFT         16'hFFFC
`define VEC_TRAP         16'hFFFA
`define VEC_WDOG         16'hFFF8
`define VEC_LOW_BASE     16'hFFF6
`define VEC_HIGH_BASE    16'hFFBE
// Acceptance sequence length in machine cycles and stack bytes pushed.
`define ACCEPT_CYCLES    4'h8
`define STACK_PUSH       8'h03
`endif

// ### irq_latch_priority.v
// Interrupt latch, enable and fixed-priority acceptance unit for an 8-bit core.
`include "irq_ctrl_defs.vh"
module irq_latch_priority (
  // Clock and reset.
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  // Hardware request pulses, one per latch index 2..23 (bits 0..1 unused).
  input  wire [23:0] hw_request_i,
  input  wire        software_trap_request_i,
  input  wire        bad_opcode_request_i,
  input  wire        ext_zero_pin_irq_enable_i,
  // Core register port, special-function space.
  input  wire [7:0]  sfr_addr_i,
  input  wire        sfr_wr_i,
  input  wire [7:0]  sfr_wdata_i,
  output reg  [7:0]  sfr_rdata_o,
  // Core sequencer handshake.
  input  wire        insn_done_i,
  input  wire        reti_i,
  input  wire        reti_imf_i,
  input  wire [7:0]  psw_i,
  input  wire [15:0] pc_i,
  output reg         irq_pending_o,
  output reg         accept_busy_o,
  output reg  [15:0] vector_o,
  output reg         push_we_o,
  output reg  [7:0]  push_data_o,
  output reg         sp_dec3_o,
  output reg         isr_start_o
);
  // Pending latches, enables and master enable.
  // Bits 0 and 1 of the latch and enable vectors have no source and stay zero.
  // Keeping both vectors 24 bits wide lets one index address every source.
  reg  [23:0] pending_request_latch_ff;  // Latched requests, bits 2..23 live.
  reg  [23:0] source_irq_enable_ff;      // Individual enables, bits 4..23 live.
  reg         master_irq_enable_ff;      // Master maskable enable.
  // Acceptance sequencer state.
  // Only one acceptance runs at a time; nesting happens between sequences.
  localparam ST_IDLE = 2'b01;
  localparam ST_SEQ  = 2'b10;
  reg  [1:0]  state_ff;
  reg  [3:0]  cyc_ff;                    // Machine cycle within acceptance.
  reg  [15:0] pc_save_ff;
  reg  [7:0]  psw_save_ff;
  // Pin input passes two flip-flops before use.
  // The pin enable is asynchronous, so only the second stage may be read.
  reg         pin_meta_ff;
  reg         pin_sync_ff;
  // Vector of a maskable latch index, descending in steps of two.
  // Index 4 maps to the top of the lower table and index 16 to the upper one.
  // The two tables are not contiguous, hence the two base addresses.
  function [15:0] vec_of;
    input [4:0] idx;
    begin
      if (idx < 5'd16) begin
        vec_of = `VEC_LOW_BASE - {10'h000, idx - 5'd4, 1'b0};
      end else begin
        vec_of = `VEC_HIGH_BASE - {10'h000, idx - 5'd16, 1'b0};
      end
    end
  endfunction
  // Gated requests and arbitration.
  // Purely combinational: the winner is recomputed every cycle.
  // Software and bad-opcode requests are levels held by the core, not latched.
  // Non-maskable sources are taken without regard to either enable.
  // Scanning from the top down leaves the lowest eligible index as the winner.
  reg  [23:0] eligible;
  reg         nmi_soft;
  reg         nmi_any;
  reg  [4:0]  win_idx;
  reg         win_found;
  reg  [15:0] win_vec;
  integer     i;
  always @* begin
    eligible = 24'h00_0000;
    for (i = 4; i < 24; i = i + 1) begin
      eligible[i] = pending_request_latch_ff[i] & source_irq_enable_ff[i] &
                    master_irq_enable_ff;
    end
    eligible[4] = eligible[4] & pin_sync_ff;
    nmi_soft  = software_trap_request_i | bad_opcode_request_i;
    // One level for every non-maskable source; trap then watchdog only picks a vector.
    nmi_any   = nmi_soft | pending_request_latch_ff[`TRAP_BIT] |
                pending_request_latch_ff[`WDOG_BIT];
    win_idx   = 5'd0;
    win_found = 1'b0;
    win_vec   = `VEC_RESET;
    if (nmi_soft) begin
      win_found = 1'b1;
      win_vec   = `VEC_SOFT;
    end else if (pending_request_latch_ff[`TRAP_BIT]) begin
      win_found = 1'b1;
      win_idx   = 5'd2;
      win_vec   = `VEC_TRAP;
    end else if (pending_request_latch_ff[`WDOG_BIT]) begin
      win_found = 1'b1;
      win_idx   = 5'd3;
      win_vec   = `VEC_WDOG;
    end else begin
      for (i = 23; i >= 4; i = i - 1) begin
        if (eligible[i]) begin
          win_found = 1'b1;
          win_idx   = i[4:0];
        end
      end
      if (win_found) begin
        win_vec = vec_of(win_idx);
      end
    end
  end
  // Clear mask from a write: zero bits clear, one bits keep.
  // A written one keeps a bit, so software can never raise a request itself.
  // Only load-type writes are safe; a read-modify-write can wipe a fresh request.
  reg  [23:0] sw_clear;
  always @* begin
    sw_clear = 24'h00_0000;
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        `ADDR_LATCH_LOW:  sw_clear[7:0]   = ~sfr_wdata_i;
        `ADDR_LATCH_HIGH: sw_clear[15:8]  = ~sfr_wdata_i;
        `ADDR_LATCH_EXT:  sw_clear[23:16] = ~sfr_wdata_i;
        default:          sw_clear        = 24'h00_0000;
      endcase
    end
  end
  // Acceptance only at an instruction boundary, and never while a sequence runs.
  wire take_now = (state_ff == ST_IDLE) && insn_done_i && win_found;
  // Pin synchroniser.
  // Reset puts the synchronised enable low, so index 4 starts blocked.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= ext_zero_pin_irq_enable_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end
  // Latches: a new request beats a clear in the same cycle.
  // That way an event in the clearing cycle is never lost.
  // Soft and bad-opcode acceptances clear nothing, as they have no latch.
  // A converter request landing while a lower source is accepted keeps its
  // latch here; losing it instead would also be legal for this device.
  reg [23:0] acc_clear;
  always @* begin
    acc_clear = 24'h00_0000;
    if (take_now && win_idx >= 5'd2) begin
      acc_clear[win_idx] = 1'b1;
    end
  end
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_request_latch_ff <= 24'h00_0000;
    end else begin
      // The mask drops bits 0 and 1, which have no source.
      pending_request_latch_ff <= ((pending_request_latch_ff & ~sw_clear & ~acc_clear) |
                                   hw_request_i) & 24'hFF_FFFC;
    end
  end
  // Enable registers; master enable also driven by acceptance and return.
  // Enable bits 3..1 of the low register do not exist and read back as zero.
  // Master enable priority: acceptance, then return, then a register write.
  // A master-enable write landing with an acceptance is lost; software disables first anyway.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_irq_enable_ff <= 24'h00_0000;
      master_irq_enable_ff <= 1'b0;
    end else begin
      if (sfr_wr_i && sfr_addr_i == `ADDR_ENABLE_LOW) begin
        source_irq_enable_ff[7:4] <= sfr_wdata_i[7:4];
      end
      if (sfr_wr_i && sfr_addr_i == `ADDR_ENABLE_HIGH) begin
        source_irq_enable_ff[15:8] <= sfr_wdata_i;
      end
      if (sfr_wr_i && sfr_addr_i == `ADDR_ENABLE_EXT) begin
        source_irq_enable_ff[23:16] <= sfr_wdata_i;
      end
      if (take_now) begin
        master_irq_enable_ff <= 1'b0;
      end else if (reti_i) begin
        master_irq_enable_ff <= reti_imf_i; // Reopens nesting.
      end else if (sfr_wr_i && sfr_addr_i == `ADDR_ENABLE_LOW) begin
        master_irq_enable_ff <= sfr_wdata_i[0];
      end
    end
  end
  // Acceptance sequencer: eight cycles, three pushes, SP down by three.
  // Cycles 1 to 3 push status, PC high and PC low; cycles 4 to 8 only wait.
  // The core is expected to stall while busy is high.
  // The vector stands until the next acceptance, so the core may fetch it late.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff      <= ST_IDLE;
      cyc_ff        <= 4'h0;
      pc_save_ff    <= 16'h0000;
      psw_save_ff   <= 8'h00;
      // After reset the vector shows the reset entry point.
      vector_o      <= `VEC_RESET;
      accept_busy_o <= 1'b0;
      push_we_o     <= 1'b0;
      push_data_o   <= 8'h00;
      sp_dec3_o     <= 1'b0;
      isr_start_o   <= 1'b0;
    end else begin
      push_we_o   <= 1'b0;
      sp_dec3_o   <= 1'b0;
      isr_start_o <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (take_now) begin
            state_ff      <= ST_SEQ;
            cyc_ff        <= 4'h1;
            vector_o      <= win_vec;
            pc_save_ff    <= pc_i;
            // Saved status carries the master enable in bit 0.
            psw_save_ff   <= {psw_i[7:1], master_irq_enable_ff};
            accept_busy_o <= 1'b1;
          end
        end
        ST_SEQ: begin
          cyc_ff <= cyc_ff + 4'h1;
          case (cyc_ff)
            4'h1: begin
              push_we_o   <= 1'b1;
              push_data_o <= psw_save_ff;
            end
            4'h2: begin
              push_we_o   <= 1'b1;
              push_data_o <= pc_save_ff[15:8];
            end
            4'h3: begin
              push_we_o   <= 1'b1;
              push_data_o <= pc_save_ff[7:0];
              sp_dec3_o   <= 1'b1;
            end
            default: begin
              // Cycles without a push keep the last byte on the bus.
              push_data_o <= push_data_o;
            end
          endcase
          // Eight machine cycles of one clock each, counted from one.
          if (cyc_ff == `ACCEPT_CYCLES) begin
            state_ff      <= ST_IDLE;
            accept_busy_o <= 1'b0;
            isr_start_o   <= 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
  // Status outputs and register read-back.
  // Read data is registered and answers one cycle after the address.
  // Unmapped addresses return zero.
  // The pending flag is registered, so it trails the latches by one cycle.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_pending_o <= 1'b0;
      sfr_rdata_o   <= 8'h00;
    end else begin
      irq_pending_o <= win_found | nmi_any;
      case (sfr_addr_i)
        `ADDR_LATCH_LOW:   sfr_rdata_o <= pending_request_latch_ff[7:0];
        `ADDR_LATCH_HIGH:  sfr_rdata_o <= pending_request_latch_ff[15:8];
        `ADDR_LATCH_EXT:   sfr_rdata_o <= pending_request_latch_ff[23:16];
        `ADDR_ENABLE_LOW:  sfr_rdata_o <= {source_irq_enable_ff[7:4], 3'b000,
                                           master_irq_enable_ff};
        `ADDR_ENABLE_HIGH: sfr_rdata_o <= source_irq_enable_ff[15:8];
        `ADDR_ENABLE_EXT:  sfr_rdata_o <= source_irq_enable_ff[23:16];
        default:           sfr_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// ### irq_latch_priority_props.sv
// Port checks for the interrupt latch and priority unit.
`include "irq_ctrl_defs.vh"
module irq_latch_priority_props (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [23:0] hw_request_i,
  input wire logic        software_trap_request_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic        insn_done_i,
  input wire logic [15:0] pc_i,
  input wire logic        irq_pending_o,
  input wire logic        accept_busy_o,
  input wire logic [15:0] vector_o,
  input wire logic        push_we_o,
  input wire logic [7:0]  push_data_o,
  input wire logic        sp_dec3_o,
  input wire logic        isr_start_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_busy;
    $rose(accept_busy_o) |-> accept_busy_o[*8] ##1 !accept_busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length wrong");
  property p_start;
    $rose(accept_busy_o) |-> ##8 isr_start_o;
  endproperty
  a_start: assert property (p_start) else $error("service start late");
  property p_push;
    $rose(accept_busy_o) |-> ##1 push_we_o[*3] ##1 !push_we_o;
  endproperty
  a_push: assert property (p_push) else $error("push count wrong");
  property p_sp;
    $rose(accept_busy_o) |-> ##3 sp_dec3_o;
  endproperty
  a_sp: assert property (p_sp) else $error("stack step missing");
  property p_pch;
    $rose(accept_busy_o) |-> ##2 ({8'h00, push_data_o} == ($past(pc_i, 3) >> 8));
  endproperty
  a_pch: assert property (p_pch) else $error("pc high byte wrong");
  property p_cause;
    $rose(accept_busy_o) |-> $past(insn_done_i);
  endproperty
  a_cause: assert property (p_cause) else $error("accept without boundary");
  property p_soft;
    insn_done_i && !accept_busy_o && software_trap_request_i |->
      ##2 vector_o == `VEC_SOFT;
  endproperty
  a_soft: assert property (p_soft) else $error("soft vector wrong");
  property p_trap;
    hw_request_i[2] |-> ##[1:2] irq_pending_o;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not pending");
  property p_unmap;
    sfr_addr_i == 8'h00 |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_acc: cover property ($rose(accept_busy_o));
  c_isr: cover property (isr_start_o);
  c_soft: cover property (software_trap_request_i && accept_busy_o);
endmodule
bind irq_latch_priority irq_latch_priority_props chk (.*);

// ### cpu_model.sv
// Core sequencer model: ends instructions and records stacked bytes.
module cpu_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] gap_i,
  input  wire logic       busy_i,
  input  wire logic       push_we_i,
  input  wire logic [7:0] push_data_i,
  output logic            insn_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] stack_q [$]; // Stacked bytes, oldest first.
  logic [3:0] cnt_q = 4'h0; // Cycles left in the running instruction.
  // No boundary while the unit stacks, as a real core is stalled then.
  always @(negedge sys_clk_i) begin
    if (!rst_n_i || busy_i) begin
      insn_done_o <= 1'b0;
      cnt_q       <= gap_i;
    end else if (cnt_q == 4'h0) begin
      insn_done_o <= 1'b1;
      cnt_q       <= gap_i;
    end else begin
      insn_done_o <= 1'b0;
      cnt_q       <= cnt_q - 4'h1;
    end
  end
  // Capture every byte pushed during acceptance.
  always @(posedge sys_clk_i) begin
    if (push_we_i) begin
      stack_q.push_back(push_data_i);
    end
  end
endmodule

// ### tb.sv
// Self-checking testbench for the interrupt latch and priority unit.
`include "irq_ctrl_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, rst_n_i = 0, wr = 0, swt = 0, bop = 0, pin = 0, reti = 0, rimf = 0;
  logic done, pend, busy, pwe, sp, isr;
  logic [23:0] hw = 0;
  logic [7:0] addr = 0, wd = 0, psw = 8'hA4, rd, pdat;
  logic [15:0] vec, pc = 16'h1234;
  logic [3:0] gap = 4'h0;
  int err_total = 0, checked = 0, cyc = 0;
  irq_latch_priority dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hw_request_i(hw),
    .software_trap_request_i(swt), .bad_opcode_request_i(bop), .ext_zero_pin_irq_enable_i(pin),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rdata_o(rd), .insn_done_i(done),
    .reti_i(reti), .reti_imf_i(rimf), .psw_i(psw), .pc_i(pc), .irq_pending_o(pend),
    .accept_busy_o(busy), .vector_o(vec), .push_we_o(pwe), .push_data_o(pdat),
    .sp_dec3_o(sp), .isr_start_o(isr));
  cpu_model m (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .gap_i(gap), .busy_i(busy),
    .push_we_i(pwe), .push_data_i(pdat), .insn_done_o(done));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  // Cut a hang short after far more cycles than the tests need.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 4000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i) {addr, wd, wr} = {a, d, 1'b1};
    @(negedge sys_clk_i) wr = 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_i) addr = a;
    @(negedge sys_clk_i) chk({8'h00, rd}, {8'h00, e});
  endtask
  task automatic pulse(input logic [23:0] v);
    @(negedge sys_clk_i) hw = v;
    @(negedge sys_clk_i) hw = 0;
  endtask
  // Wait a bounded time for the service routine to start, then check its vector.
  task automatic accept(input logic [15:0] v);
    for (int i = 0; i < 60 && isr !== 1'b1; i++) @(negedge sys_clk_i);
    chk({15'h0, isr}, 16'h0001);
    chk(vec, v);
  endtask
  task automatic t_reset();
    logic [7:0] regs [6] = '{`ADDR_LATCH_LOW, `ADDR_LATCH_HIGH, `ADDR_LATCH_EXT,
                             `ADDR_ENABLE_LOW, `ADDR_ENABLE_HIGH, `ADDR_ENABLE_EXT};
    chk(vec, `VEC_RESET);
    foreach (regs[i]) rchk(regs[i], 8'h00);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_latch();
    pulse(24'h00_0200);
    rchk(`ADDR_LATCH_HIGH, 8'h02);
    wreg(`ADDR_LATCH_HIGH, 8'hFF);
    rchk(`ADDR_LATCH_HIGH, 8'h02);
    wreg(`ADDR_LATCH_HIGH, 8'h00); // Load-type write only.
    rchk(`ADDR_LATCH_HIGH, 8'h00);
    pulse(24'h80_0000);
    rchk(`ADDR_LATCH_EXT, 8'h80);
    wreg(`ADDR_LATCH_EXT, 8'h7F);
    rchk(`ADDR_LATCH_EXT, 8'h00);
  endtask
  task automatic t_prio();
    wreg(`ADDR_ENABLE_LOW, 8'h30); // Master stays off during edits.
    wreg(`ADDR_ENABLE_HIGH, 8'h02);
    pulse(24'h00_0230);
    // Let the registered pending flag catch up before looking at it.
    @(negedge sys_clk_i);
    chk({15'h0, pend}, 16'h0000);
    m.stack_q.delete();
    wreg(`ADDR_ENABLE_LOW, 8'h31);
    accept(16'hFFF4); // Index 4 held off by its pin enable.
    chk({8'h0, m.stack_q[0]}, 16'h00A5); // Status with master enable.
    chk({m.stack_q[1], m.stack_q[2]}, pc);
    rchk(`ADDR_LATCH_LOW, 8'h10);
    chk({15'h0, pend}, 16'h0000);
    wreg(`ADDR_ENABLE_LOW, 8'h01); // Edits first, then master.
    accept(16'hFFEC); // Nested acceptance.
    @(negedge sys_clk_i) {reti, rimf} = 2'b11;
    @(negedge sys_clk_i) {reti, rimf} = 2'b00;
    rchk(`ADDR_ENABLE_LOW, 8'h01); // Return restores master.
    wreg(`ADDR_ENABLE_LOW, 8'h00); // Master off before edits.
    @(negedge sys_clk_i) pin = 1;
    wreg(`ADDR_ENABLE_LOW, 8'h10);
    wreg(`ADDR_ENABLE_LOW, 8'h11);
    accept(`VEC_LOW_BASE); // Pin enable now high.
  endtask
  task automatic t_nmi();
    pulse(24'h00_0080); // Index 7 is not enabled and stays pending.
    pulse(24'h00_0004); // Trap action select taken as cleared.
    accept(`VEC_TRAP);
    pulse(24'h00_0008); // Watchdog action select taken as cleared.
    accept(`VEC_WDOG);
    gap = 4'h5;
    @(negedge sys_clk_i) swt = 1;
    accept(`VEC_SOFT);
    swt = 0;
    @(negedge sys_clk_i) bop = 1;
    accept(`VEC_SOFT);
    bop = 0;
    rchk(`ADDR_LATCH_LOW, 8'h80);
    wreg(`ADDR_LATCH_LOW, 8'h0C); // Trap and watchdog bits written as one.
    rchk(`ADDR_LATCH_LOW, 8'h00);
  endtask
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge sys_clk_i);
    rst_n_i = 1;
    t_reset();
    t_latch();
    t_prio();
    t_nmi();
    test_done();
  end
endmodule
